// File: inc/msc_consts.svh
// Timing constants for the module system controller.
`ifndef MSC_CONSTS_SVH
`define MSC_CONSTS_SVH
`define MSC_CLK_PERIOD_PS 5000
`define MSC_BLINK_PERIOD_MS 1000
`define MSC_BLINK_HALF_CYCLES ((`MSC_BLINK_PERIOD_MS * 64'd1000000000 / `MSC_CLK_PERIOD_PS) / 2)
`define MSC_SETTLE_US 1000
`define MSC_SETTLE_CYCLES ((`MSC_SETTLE_US * 64'd1000000 + `MSC_CLK_PERIOD_PS - 1) / `MSC_CLK_PERIOD_PS)
`define MSC_RST_SYNC_STAGES 2
`endif

// File: inc/msc_pkg.sv
// Types for the module system controller.
package msc_pkg;
	typedef enum logic [1:0] {
		MSC_WAIT_SUPPLY,
		MSC_SETTLE,
		MSC_RUN
	} msc_seq_type;
endpackage : msc_pkg

// File: rtl/msc_blinker.sv
// Free-running square wave divider for the status lamps.
`timescale 1ns/100ps
`include "msc_consts.svh"
module msc_blinker #(
	parameter int unsigned HALF_CYCLES = 32'(`MSC_BLINK_HALF_CYCLES)
) (
	input wire logic ref_clk_i,
	input wire logic sys_rst_i,
	output logic blink_o
);
	logic [31:0] cnt_q;
	logic [31:0] cnt_d;
	logic blink_q;
	logic blink_d;

	always_comb begin
		cnt_d = cnt_q + 32'h1;
		blink_d = blink_q;
		if (cnt_q >= HALF_CYCLES - 1) begin
			cnt_d = 32'h0;
			blink_d = ~blink_q;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			cnt_q <= 32'h0;
			blink_q <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			blink_q <= blink_d;
		end
	end

	assign blink_o = blink_q;
endmodule : msc_blinker

// File: rtl/msc_controller.sv
// Module system controller: supply sequencing, reset merge, scan routing and lamps.
// Summary of operation
// - Scan port goes to main device when select low or open, else to controller.
// - Supply-ok output is high only while every on-module supply is good.
// - External reset low drives the main device program line low.
// - Auxiliary reset acts like external reset; unconnected reads high, no reset.
// - Both status lamps flash while the main device is unconfigured.
// - After configuration the user design drives the status lamps.
// - Program line is held low until supplies have settled after power-up.
// - Auxiliary reset only resets the main device, supplies stay enabled.
`timescale 1ns/100ps
`include "msc_consts.svh"
module msc_controller #(
	parameter int unsigned SETTLE_CYCLES = 32'(`MSC_SETTLE_CYCLES),
	parameter int unsigned BLINK_HALF_CYCLES = 32'(`MSC_BLINK_HALF_CYCLES)
) (
	input wire logic ref_clk_i,
	input wire logic sys_rst_i,
	input wire logic supplies_good_i,
	input wire logic ext_reset_n_in_i,
	input wire logic aux_reset_in_i,
	input wire logic scan_target_select_i,
	input wire logic fpga_done_i,
	input wire logic user_lamp_green_i,
	input wire logic user_lamp_red_i,
	input wire logic scan_tck_i,
	input wire logic scan_tms_i,
	input wire logic scan_tdi_i,
	input wire logic fpga_tdo_i,
	input wire logic ctrl_tdo_i,
	output logic supply_ok_out_o,
	output logic supply_enable_o,
	output logic fpga_program_n_o,
	output logic status_lamp_green_o,
	output logic status_lamp_red_o,
	output logic fpga_tck_o,
	output logic fpga_tms_o,
	output logic fpga_tdi_o,
	output logic ctrl_tck_o,
	output logic ctrl_tms_o,
	output logic ctrl_tdi_o,
	output logic scan_tdo_o
);
	import msc_pkg::*;

	// ****************************************
	// Reset request merge.
	// ****************************************
	logic rst_req;

	// Reset requests are active low; an open auxiliary pin is pulled high.
	assign rst_req = ~ext_reset_n_in_i | ~aux_reset_in_i;

	// ****************************************
	// Power-up sequencing.
	// ****************************************
	// A supply that drops restarts the whole settling delay before release.
	msc_seq_type state_q;
	msc_seq_type state_d;
	logic [31:0] settle_q;
	logic [31:0] settle_d;
	logic settle_done;
	logic prog_n_d;
	logic prog_n_q;
	logic ok_d;
	logic ok_q;

	assign settle_done = (settle_q >= SETTLE_CYCLES - 1);

	always_comb begin
		state_d = state_q;
		settle_d = settle_q;
		unique case (state_q)
			MSC_WAIT_SUPPLY: begin
				settle_d = 32'h0;
				if (supplies_good_i) begin
					state_d = MSC_SETTLE;
				end
			end
			MSC_SETTLE: begin
				settle_d = settle_q + 32'h1;
				if (!supplies_good_i) begin
					state_d = MSC_WAIT_SUPPLY;
				end else if (settle_done) begin
					state_d = MSC_RUN;
				end
			end
			MSC_RUN: begin
				if (!supplies_good_i) begin
					state_d = MSC_WAIT_SUPPLY;
				end
			end
		endcase
		ok_d = supplies_good_i && (state_d == MSC_RUN);
		prog_n_d = (state_d == MSC_RUN) && !rst_req;
	end

	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			state_q <= MSC_WAIT_SUPPLY;
			settle_q <= 32'h0;
			ok_q <= 1'b0;
			prog_n_q <= 1'b0;
		end else begin
			state_q <= state_d;
			settle_q <= settle_d;
			ok_q <= ok_d;
			prog_n_q <= prog_n_d;
		end
	end

	// ****************************************
	// Status lamps.
	// ****************************************
	logic blink;
	logic green_d;
	logic red_d;
	logic green_q;
	logic red_q;

	msc_blinker #(
		.HALF_CYCLES(BLINK_HALF_CYCLES)
	) u_blinker (
		.ref_clk_i(ref_clk_i),
		.sys_rst_i(sys_rst_i),
		.blink_o(blink)
	);

	// Lamps are handed over only while the program line is released.
	always_comb begin
		green_d = blink;
		red_d = blink;
		if (fpga_done_i && prog_n_q) begin
			green_d = user_lamp_green_i;
			red_d = user_lamp_red_i;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			green_q <= 1'b0;
			red_q <= 1'b0;
		end else begin
			green_q <= green_d;
			red_q <= red_d;
		end
	end

	// ****************************************
	// Scan port routing.
	// ****************************************
	// Select is registered, so a routing change lands two clocks after it moves.
	logic sel_d;
	logic sel_q;
	logic [2:0] fpga_scan_d;
	logic [2:0] fpga_scan_q;
	logic [2:0] ctrl_scan_d;
	logic [2:0] ctrl_scan_q;
	logic tdo_d;
	logic tdo_q;

	always_comb begin
		sel_d = scan_target_select_i;
		fpga_scan_d = 3'h0;
		ctrl_scan_d = 3'h0;
		if (sel_q) begin
			ctrl_scan_d = {scan_tck_i, scan_tms_i, scan_tdi_i};
			tdo_d = ctrl_tdo_i;
		end else begin
			fpga_scan_d = {scan_tck_i, scan_tms_i, scan_tdi_i};
			tdo_d = fpga_tdo_i;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			sel_q <= 1'b0;
			fpga_scan_q <= 3'h0;
			ctrl_scan_q <= 3'h0;
			tdo_q <= 1'b0;
		end else begin
			sel_q <= sel_d;
			fpga_scan_q <= fpga_scan_d;
			ctrl_scan_q <= ctrl_scan_d;
			tdo_q <= tdo_d;
		end
	end

	// ****************************************
	// Supply enable.
	// ****************************************
	logic en_d;
	logic en_q;

	always_comb begin
		en_d = 1'b1;
	end

	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			en_q <= 1'b1;
		end else begin
			en_q <= en_d;
		end
	end

	// ****************************************
	// Outputs.
	// ****************************************
	assign supply_ok_out_o = ok_q;
	// Supplies stay enabled whatever the reset inputs do.
	assign supply_enable_o = en_q;
	assign fpga_program_n_o = prog_n_q;
	assign status_lamp_green_o = green_q;
	assign status_lamp_red_o = red_q;
	// The unselected scan target sees its lines held low.
	assign {fpga_tck_o, fpga_tms_o, fpga_tdi_o} = fpga_scan_q;
	assign {ctrl_tck_o, ctrl_tms_o, ctrl_tdi_o} = ctrl_scan_q;
	assign scan_tdo_o = tdo_q;
endmodule : msc_controller

// File: dv/msc_board_model.sv
// Main device configuration model.
`timescale 1ns/100ps
module msc_board_model (
	input wire logic ref_clk_i,
	input wire logic fpga_program_n_o,
	input wire logic fpga_tdi_o,
	output logic fpga_done_i = '0,
	output logic fpga_tdo_i = '0
);
	always @(posedge ref_clk_i) fpga_done_i <= fpga_program_n_o;
	always @(posedge ref_clk_i) fpga_tdo_i <= fpga_tdi_o;
endmodule : msc_board_model

// File: dv/msc_controller_props.sv
// Port checker for the system controller.
`timescale 1ns/100ps
module msc_controller_props #(
	parameter int unsigned SETTLE_CYCLES = 4
) (
	input wire logic ref_clk_i,
	input wire logic sys_rst_i,
	input wire logic supplies_good_i,
	input wire logic ext_reset_n_in_i,
	input wire logic aux_reset_in_i,
	input wire logic scan_target_select_i,
	input wire logic scan_tck_i,
	input wire logic fpga_done_i,
	input wire logic user_lamp_green_i,
	input wire logic user_lamp_red_i,
	input wire logic supply_ok_out_o,
	input wire logic ctrl_tck_o,
	input wire logic supply_enable_o,
	input wire logic fpga_program_n_o,
	input wire logic status_lamp_green_o,
	input wire logic status_lamp_red_o,
	input wire logic fpga_tck_o
);
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (sys_rst_i);
	ext_hold_a: assert property (!ext_reset_n_in_i |=> !fpga_program_n_o)
		else $error("ext hold");
	aux_hold_a: assert property (!aux_reset_in_i |=>
		!fpga_program_n_o && supply_enable_o) else $error("aux hold");
	supply_drop_a: assert property (!supplies_good_i |=> !supply_ok_out_o)
		else $error("ok stuck");
	settle_wait_a: assert property ($rose(supply_ok_out_o) |->
		$past(supplies_good_i, SETTLE_CYCLES + 1)) else $error("ok early");
	run_order_a: assert property (fpga_program_n_o |-> supply_ok_out_o)
		else $error("run early");
	fpga_route_a: assert property (!scan_target_select_i [*2] |=>
		fpga_tck_o == $past(scan_tck_i) && !ctrl_tck_o) else $error("main route");
	ctrl_route_a: assert property (scan_target_select_i [*2] |=>
		ctrl_tck_o == $past(scan_tck_i) && !fpga_tck_o) else $error("ctrl route");
	lamp_pair_a: assert property (!fpga_done_i |=> status_lamp_green_o == status_lamp_red_o)
		else $error("lamps apart");
	lamp_release_a: assert property (fpga_done_i && fpga_program_n_o |=>
		status_lamp_green_o == $past(user_lamp_green_i) &&
		status_lamp_red_o == $past(user_lamp_red_i)) else $error("lamps held");
	cover property ($rose(supply_ok_out_o));
	cover property ($fell(supply_ok_out_o));
	cover property (fpga_done_i);
	cover property (scan_target_select_i [*2]);
endmodule : msc_controller_props
bind msc_controller msc_controller_props #(.SETTLE_CYCLES(SETTLE_CYCLES))
	i_msc_controller_props (.*);

// File: dv/msc_controller_test.sv
// Bench for the system controller.
`timescale 1ns/100ps
module msc_controller_test;
	logic ref_clk_i = '0, sys_rst_i = '1, supplies_good_i = '0, ext_reset_n_in_i = '1, b;
	logic aux_reset_in_i = '1, scan_target_select_i = '0, user_lamp_green_i = '0, ctrl_tdo_i = '0;
	logic user_lamp_red_i = '0, scan_tck_i = '0, scan_tms_i = '0, scan_tdi_i = '0, fpga_done_i;
	logic fpga_tdo_i, supply_ok_out_o, supply_enable_o, fpga_program_n_o, fpga_tck_o, ctrl_tdi_o;
	logic status_lamp_green_o, status_lamp_red_o, fpga_tms_o, fpga_tdi_o, ctrl_tck_o, ctrl_tms_o;
	logic scan_tdo_o;
	int err_total, samples_checked, cyc, n;
	msc_controller #(.SETTLE_CYCLES(4), .BLINK_HALF_CYCLES(3)) i_msc_controller (.*);
	msc_board_model i_msc_board_model (.*);
	initial forever #2.5 ref_clk_i = ~ref_clk_i;
	always @(posedge ref_clk_i) if (++cyc > 999) begin
		err_total++;
		close_out();
	end
	task automatic chk(string s, logic a, logic e);
		samples_checked++;
		if (a !== e) begin
			err_total++;
			$display("CHECK FAILED %s exp %b seen %b", s, e, a);
		end
	endtask : chk
	task automatic tk(int c);
		repeat (c) @(negedge ref_clk_i);
	endtask : tk
	task automatic t_hold(logic x);
		@(posedge ref_clk_i) {ext_reset_n_in_i, aux_reset_in_i} <= {x, !x};
		tk(5);
		chk("held", fpga_program_n_o, '0);
		chk("enable", supply_enable_o, '1);
		chk("ok kept", supply_ok_out_o, '1);
		n = 0;
		repeat (12) begin
			b = status_lamp_green_o;
			tk(1);
			n += int'(b !== status_lamp_green_o);
		end
		chk("blink", n == 4, '1);
		@(posedge ref_clk_i) {ext_reset_n_in_i, aux_reset_in_i} <= '1;
	endtask : t_hold
	task automatic t_scan(logic s);
		@(posedge ref_clk_i) {scan_target_select_i, ctrl_tdo_i} <= {s, s};
		{scan_tck_i, scan_tms_i, scan_tdi_i} <= 3'h7;
		tk(6);
		chk("fpga tck", fpga_tck_o, !s);
		chk("fpga tms", fpga_tms_o, !s);
		chk("fpga tdi", fpga_tdi_o, !s);
		chk("ctrl tck", ctrl_tck_o, s);
		chk("ctrl tms", ctrl_tms_o, s);
		chk("ctrl tdi", ctrl_tdi_o, s);
		chk("tdo", scan_tdo_o, '1);
	endtask : t_scan
	task automatic t_drop();
		@(posedge ref_clk_i) supplies_good_i <= '0;
		tk(2);
		chk("ok lost", supply_ok_out_o, '0);
		chk("held lost", fpga_program_n_o, '0);
		@(posedge ref_clk_i) supplies_good_i <= '1;
		tk(5);
		chk("ok settling", supply_ok_out_o, '0);
		chk("held settling", fpga_program_n_o, '0);
		tk(1);
		chk("ok back", supply_ok_out_o, '1);
		chk("run back", fpga_program_n_o, '1);
	endtask : t_drop
	task automatic close_out();
		$display("errors %0d checks %0d", err_total, samples_checked);
		if (err_total == 0 && samples_checked > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : close_out
	initial begin
		repeat (3) @(posedge ref_clk_i);
		sys_rst_i <= '0;
		@(posedge ref_clk_i) {supplies_good_i, user_lamp_green_i} <= '1;
		tk(7);
		chk("ok", supply_ok_out_o, '1);
		tk(3);
		chk("lamp", status_lamp_green_o, '1);
		chk("lamp red", status_lamp_red_o, '0);
		t_hold('0);
		t_hold('1);
		t_scan('0);
		t_scan('1);
		t_drop();
		close_out();
	end
endmodule : msc_controller_test
